// >>> design/phi_pkg.sv
// Purpose: shared constants and the instruction descriptor for the hazard interlock
// Assumes: seven stages, eight auxiliary address registers, four data registers
// Notes: stage numbers index the pipeline array, oldest stage has the highest number
package phi_pkg;
    localparam int PHI_STAGES = 7;
    localparam int PHI_ST_DEC = 0;
    localparam int PHI_ST_ADR = 1;
    localparam int PHI_ST_AC1 = 2;
    localparam int PHI_ST_AC2 = 3;
    localparam int PHI_ST_RD = 4;
    localparam int PHI_ST_EX = 5;
    localparam int PHI_ST_WR = 6;
    localparam int PHI_AUX_NUM = 8;
    localparam int PHI_DREG_NUM = 4;
    localparam int PHI_DATA_W = 16;
    localparam logic [15:0] PHI_AUX_RST = 16'h0000;
    localparam logic [15:0] PHI_DREG_RST = 16'h0000;
    localparam logic PHI_CPL_RST = 1'h0;

    typedef struct packed {
        logic valid;
        logic amod_wr;
        logic [2:0] amod_reg;
        logic [15:0] amod_val;
        logic ag_rd;
        logic [2:0] ag_reg;
        logic pf_rd;
        logic [2:0] pf_reg;
        logic x_wr;
        logic [2:0] x_reg;
        logic [15:0] x_val;
        logic mem_acc;
        logic st1_wr;
        logic st1_cpl;
        logic dr_rd;
        logic dr_wr;
        logic dr_mmr;
        logic [1:0] dr_reg;
        logic [15:0] dr_val;
    } phi_instr_t;
endpackage

// >>> design/phi_interlock.sv
// Purpose: seven-stage pipeline with interlock for aux address registers and the mode flag
// Assumes: one instruction issued per clock at most, inputs synchronous to core_clk_in
// Notes: register values are modelled here so that read and write timing is observable
//
// Summary of operation
// [RL1] an address-modify write lands in the address stage so a next address-stage user sees it
// [RL2] an address-modify write after a read-stage reader of that register holds two cycles
// [RL3] the held writer waits until the older reader has reached its read stage
// [RL4] a prefetch reader reads at the start of read stage while the writer updates at its end
// [RL5] the prefetched read returns the old value and the same-cycle write is not lost
// [RL6] a plain execute-stage update of an aux register after a read-stage read never stalls
// [RL7] a register operand reached through memory-mapped addressing is read in the read stage
// [RL8] a memory access after a memory-mapped mode-flag write is held in decode, five cycles
// [RL9] the flag write completes in write stage, decode samples it by bypass and advances in that same cycle
// [RL10] data registers use execute stage, or read and write stages when memory-mapped
// [RL11] address-modify updates use their own address-stage write port
// [RL12] each instruction moves one stage per clock unless the interlock holds it
`timescale 1ns/1ps
module phi_interlock
    import phi_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic issue_valid_in,
    input wire phi_instr_t issue_instr_in,
    output logic issue_ready_out,
    output logic [PHI_STAGES-1:0] stage_valid_out,
    output logic stall_adr_out,
    output logic stall_dec_out,
    output logic addr_valid_out,
    output logic [PHI_DATA_W-1:0] addr_out,
    output logic pf_valid_out,
    output logic [PHI_DATA_W-1:0] pf_data_out,
    output logic dr_valid_out,
    output logic [PHI_DATA_W-1:0] dr_data_out,
    output logic cpl_out,
    output logic dec_valid_out,
    output logic dec_cpl_out
);
    // one descriptor per stage, index 0 is decode
    // bubbles are all-zero descriptors, so valid low means empty
    phi_instr_t st_q [PHI_STAGES];
    phi_instr_t st_d [PHI_STAGES];
    logic [PHI_DATA_W-1:0] aux_address_register_q [PHI_AUX_NUM];
    logic [PHI_DATA_W-1:0] dreg_q [PHI_DREG_NUM];
    logic addressing_mode_flag_q;
    logic addr_valid_q;
    logic [PHI_DATA_W-1:0] addr_q;
    logic pf_valid_q;
    logic [PHI_DATA_W-1:0] pf_data_q;
    logic dr_valid_q;
    logic [PHI_DATA_W-1:0] dr_data_q;
    logic dec_valid_q;
    logic dec_cpl_q;

    wire phi_instr_t adr_i = st_q[PHI_ST_ADR];
    wire phi_instr_t dec_i = st_q[PHI_ST_DEC];
    wire phi_instr_t rd_i = st_q[PHI_ST_RD];
    wire phi_instr_t ex_i = st_q[PHI_ST_EX];
    wire phi_instr_t wr_i = st_q[PHI_ST_WR];

    // readers still in the access stages have not prefetched yet; once in read stage
    // they sample before the edge, so the writer may go in that same cycle
    wire ac1_conflict = st_q[PHI_ST_AC1].valid && st_q[PHI_ST_AC1].pf_rd
        && st_q[PHI_ST_AC1].pf_reg == adr_i.amod_reg;
    wire ac2_conflict = st_q[PHI_ST_AC2].valid && st_q[PHI_ST_AC2].pf_rd
        && st_q[PHI_ST_AC2].pf_reg == adr_i.amod_reg;
    wire adr_stall = adr_i.valid && adr_i.amod_wr && (ac1_conflict || ac2_conflict); // [RL2]

    logic flag_wr_pending;
    always_comb begin
        flag_wr_pending = 1'b0;
        // writer already in write stage is not pending: its value is bypassed below
        for (int s = PHI_ST_ADR; s <= PHI_ST_EX; s++) begin
            if (st_q[s].valid && st_q[s].st1_wr) begin
                flag_wr_pending = 1'b1;
            end
        end
    end
    wire dec_stall = dec_i.valid && dec_i.mem_acc && flag_wr_pending; // [RL8]
    wire wr_flag_now = wr_i.valid && wr_i.st1_wr;
    wire cpl_eff = wr_flag_now ? wr_i.st1_cpl : addressing_mode_flag_q; // [RL9]
    // decode must also wait behind a held address stage,
    // otherwise the decode instruction would be lost, since the held writer keeps the address stage
    wire dec_hold = dec_i.valid && (adr_stall || dec_stall);
    wire adr_adv = adr_i.valid && !adr_stall;
    wire dec_adv = dec_i.valid && !dec_hold;

    assign issue_ready_out = !dec_hold;
    assign stall_adr_out = adr_stall;
    assign stall_dec_out = dec_hold;

    always_comb begin
        st_d[PHI_ST_WR] = st_q[PHI_ST_EX]; // [RL12]
        st_d[PHI_ST_EX] = st_q[PHI_ST_RD];
        st_d[PHI_ST_RD] = st_q[PHI_ST_AC2];
        st_d[PHI_ST_AC2] = st_q[PHI_ST_AC1];
        // a held writer sends a bubble ahead of it into the first access stage rather than duplicating itself
        st_d[PHI_ST_AC1] = adr_stall ? '0 : adr_i; // [RL3]
        if (adr_stall) begin
            st_d[PHI_ST_ADR] = adr_i;
        end else if (dec_stall) begin
            st_d[PHI_ST_ADR] = '0;
        end else begin
            st_d[PHI_ST_ADR] = dec_i;
        end
        if (dec_hold) begin
            st_d[PHI_ST_DEC] = dec_i;
        end else if (issue_valid_in) begin
            st_d[PHI_ST_DEC] = issue_instr_in;
        end else begin
            st_d[PHI_ST_DEC] = '0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        for (int s = 0; s < PHI_STAGES; s++) begin
            st_q[s] <= srst_in ? '0 : st_d[s];
        end
    end

    // execute-stage update first, address-stage update last: the address-stage
    // instruction is younger, so it wins a same-cycle clash on one register
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            for (int r = 0; r < PHI_AUX_NUM; r++) begin
                aux_address_register_q[r] <= PHI_AUX_RST;
            end
        end else begin
            if (ex_i.valid && ex_i.x_wr) begin
                aux_address_register_q[ex_i.x_reg] <= ex_i.x_val; // [RL6]
            end
            if (adr_adv && adr_i.amod_wr) begin
                aux_address_register_q[adr_i.amod_reg] <= adr_i.amod_val; // [RL1] [RL11]
            end
        end
    end

    // data registers: plain access in execute, memory-mapped access in read and write
    // limitation: a same-cycle read of both kinds reports only the memory-mapped one
    wire dr_x_wr = ex_i.valid && ex_i.dr_wr && !ex_i.dr_mmr;
    wire dr_w_wr = wr_i.valid && wr_i.dr_wr && wr_i.dr_mmr;
    wire dr_x_rd = ex_i.valid && ex_i.dr_rd && !ex_i.dr_mmr;
    wire dr_r_rd = rd_i.valid && rd_i.dr_rd && rd_i.dr_mmr;

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            for (int r = 0; r < PHI_DREG_NUM; r++) begin
                dreg_q[r] <= PHI_DREG_RST;
            end
        end else begin
            if (dr_w_wr) begin
                dreg_q[wr_i.dr_reg] <= wr_i.dr_val; // [RL10]
            end
            if (dr_x_wr) begin
                dreg_q[ex_i.dr_reg] <= ex_i.dr_val; // [RL10]
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            addressing_mode_flag_q <= PHI_CPL_RST;
        end else if (wr_flag_now) begin
            addressing_mode_flag_q <= wr_i.st1_cpl; // [RL9]
        end
    end

    // all reads sample the pre-edge array, so a same-edge write cannot disturb them
    wire [PHI_DATA_W-1:0] pf_value = aux_address_register_q[rd_i.pf_reg]; // [RL4] [RL5]
    wire [PHI_DATA_W-1:0] dr_r_value = dreg_q[rd_i.dr_reg]; // [RL7]
    wire [PHI_DATA_W-1:0] dr_x_value = dreg_q[ex_i.dr_reg];

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            addr_valid_q <= 1'b0;
            addr_q <= '0;
            pf_valid_q <= 1'b0;
            pf_data_q <= '0;
            dr_valid_q <= 1'b0;
            dr_data_q <= '0;
            dec_valid_q <= 1'b0;
            dec_cpl_q <= PHI_CPL_RST;
        end else begin
            addr_valid_q <= adr_adv && adr_i.ag_rd;
            if (adr_adv && adr_i.ag_rd) begin
                addr_q <= aux_address_register_q[adr_i.ag_reg]; // [RL1]
            end
            pf_valid_q <= rd_i.valid && rd_i.pf_rd;
            if (rd_i.valid && rd_i.pf_rd) begin
                pf_data_q <= pf_value; // [RL5]
            end
            // memory-mapped read in read stage takes priority over an older-form read
            dr_valid_q <= dr_r_rd || dr_x_rd;
            if (dr_r_rd) begin
                dr_data_q <= dr_r_value; // [RL7]
            end else if (dr_x_rd) begin
                dr_data_q <= dr_x_value; // [RL10]
            end
            dec_valid_q <= dec_adv;
            if (dec_adv) begin
                dec_cpl_q <= cpl_eff; // [RL9]
            end
        end
    end

    // occupancy straight from the stage flops
    always_comb begin
        for (int s = 0; s < PHI_STAGES; s++) begin
            stage_valid_out[s] = st_q[s].valid;
        end
    end

    assign addr_valid_out = addr_valid_q;
    assign addr_out = addr_q;
    assign pf_valid_out = pf_valid_q;
    assign pf_data_out = pf_data_q;
    assign dr_valid_out = dr_valid_q;
    assign dr_data_out = dr_data_q;
    assign cpl_out = addressing_mode_flag_q;
    assign dec_valid_out = dec_valid_q;
    assign dec_cpl_out = dec_cpl_q;
endmodule

// >>> tb/phi_interlock_sva.sv
// Purpose: port timing checks for the interlock
// Assumes: one clock, srst_in synchronous active high
// Notes: read kinds are not visible here, only stage timing
`timescale 1ns/1ps
module phi_interlock_sva
    import phi_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic [PHI_STAGES-1:0] stage_valid_out,
    input wire logic stall_adr_out,
    input wire logic stall_dec_out,
    input wire logic addr_valid_out,
    input wire logic pf_valid_out,
    input wire logic cpl_out,
    input wire logic dec_valid_out,
    input wire logic dec_cpl_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    sequence s_adr_free;
        ##[1:2] !stall_adr_out;
    endsequence
    AST_ADR_BOUND: assert property ($rose(stall_adr_out) |-> s_adr_free)
        else $error("adr hold too long");
    AST_ADR_CAUSE: assert property (stall_adr_out |-> |stage_valid_out[3:2])
        else $error("adr hold with no reader ahead");
    // wider than five: a held writer can delay the flag writer too
    AST_DEC_BOUND: assert property ($rose(stall_dec_out) |-> ##[1:7] !stall_dec_out)
        else $error("decode hold too long");
    AST_ADVANCE: assert property (!$past(srst_in) |->
        stage_valid_out[6:3] == $past(stage_valid_out[5:2]))
        else $error("late stages did not advance");
    AST_ADDR_AT_ADR: assert property (addr_valid_out |->
        $past(stage_valid_out[1] && !stall_adr_out))
        else $error("addr pulse without adr exit");
    AST_PF_AT_RD: assert property (pf_valid_out |-> $past(stage_valid_out[4]))
        else $error("prefetch pulse without read stage");
    AST_CPL_AT_WR: assert property (!$past(srst_in) && $changed(cpl_out) |->
        $past(stage_valid_out[6]))
        else $error("flag changed without write stage");
    AST_DEC_FLAG: assert property (dec_valid_out |-> dec_cpl_out == cpl_out)
        else $error("decode sampled stale flag");
endmodule
bind phi_interlock phi_interlock_sva u_sva (
    .core_clk_in, .srst_in, .stage_valid_out, .stall_adr_out, .stall_dec_out,
    .addr_valid_out, .pf_valid_out, .cpl_out, .dec_valid_out, .dec_cpl_out
);

// >>> tb/phi_interlock_tb.sv
// Purpose: self-checking bench for the interlock
// Assumes: inputs change at the rising edge, outputs read at the falling edge
// Notes: stalls are counted, read results matched against queued notes
`timescale 1ns/1ps
module phi_interlock_tb
    import phi_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic issue_valid_in = 1'b0;
    phi_instr_t issue_instr_in = '0;
    logic issue_ready_out, stall_adr_out, stall_dec_out, addr_valid_out, pf_valid_out;
    logic dr_valid_out, cpl_out, dec_valid_out, dec_cpl_out, exp_cpl = 1'b0;
    logic [6:0] stage_valid_out;
    logic [15:0] addr_out, pf_data_out, dr_data_out, a, aux[8];
    logic [15:0] addr_q[$], pf_q[$], dr_q[$], dec_q[$];
    logic [31:0] seed = 32'hC0CB;
    int bad_count = 0, n_compared = 0, n_adr = 0, n_dec = 0;
    always #4 core_clk_in = ~core_clk_in;
    phi_interlock u_phi_interlock (.core_clk_in, .srst_in, .issue_valid_in, .issue_instr_in,
        .issue_ready_out, .stage_valid_out, .stall_adr_out, .stall_dec_out, .addr_valid_out,
        .addr_out, .pf_valid_out, .pf_data_out, .dr_valid_out, .dr_data_out, .cpl_out,
        .dec_valid_out, .dec_cpl_out);
    function automatic logic [15:0] pop(ref logic [15:0] q[$]);
        return q.size() ? q.pop_front() : 16'hXXXX;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic void rnd(output logic [15:0] v);
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        v = seed[15:0];
    endfunction
    // holds the offer until taken; the caller lowers valid only via idle
    task automatic iss(input phi_instr_t i, input logic [15:0] e);
        int n;
        n = 0;
        i.valid = 1'b1;
        dec_q.push_back({15'h0, exp_cpl});
        if (i.st1_wr) exp_cpl = i.st1_cpl;
        if (i.ag_rd) addr_q.push_back(e);
        if (i.pf_rd) pf_q.push_back(e);
        if (i.dr_rd) dr_q.push_back(e);
        issue_valid_in <= 1'b1;
        issue_instr_in <= i;
        do @(negedge core_clk_in); while (!issue_ready_out && ++n < 20);
        if (n >= 20) bad_count++;
        @(posedge core_clk_in);
    endtask
    task automatic idle(input int n);
        issue_valid_in <= 1'b0;
        repeat (n) @(posedge core_clk_in);
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(negedge core_clk_in) begin
        if (!srst_in) begin
            n_adr += stall_adr_out;
            n_dec += stall_dec_out;
            if (addr_valid_out) chk(addr_out, pop(addr_q), "addr");
            if (pf_valid_out) chk(pf_data_out, pop(pf_q), "pf_data");
            if (dr_valid_out) chk(dr_data_out, pop(dr_q), "dr_data");
            if (dec_valid_out) chk({15'h0, dec_cpl_out}, pop(dec_q), "dec_cpl");
        end
    end
    initial begin
        #40000;
        bad_count++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge core_clk_in);
        srst_in <= 1'b0;
        idle(2);
        for (int r = 0; r < 8; r++) begin
            rnd(aux[r]);
            iss('{amod_wr:1'b1, amod_reg:r[2:0], amod_val:aux[r], default:'0}, 16'h0);
            iss('{ag_rd:1'b1, ag_reg:r[2:0], default:'0}, aux[r]);
        end
        idle(12);
        chk(n_adr[15:0], 16'h0, "adr_hold");
        $display("done amod_then_use");
        n_adr = 0;
        rnd(a);
        iss('{pf_rd:1'b1, pf_reg:3'h2, default:'0}, aux[2]);
        iss('{amod_wr:1'b1, amod_reg:3'h2, amod_val:a, default:'0}, 16'h0);
        iss('{ag_rd:1'b1, ag_reg:3'h2, default:'0}, a);
        idle(12);
        chk(n_adr[15:0], 16'h2, "adr_hold");
        $display("done read_then_amod");
        n_adr = 0;
        rnd(a);
        iss('{pf_rd:1'b1, pf_reg:3'h3, default:'0}, aux[3]);
        iss('{x_wr:1'b1, x_reg:3'h3, x_val:a, default:'0}, 16'h0);
        idle(8);
        iss('{ag_rd:1'b1, ag_reg:3'h3, default:'0}, a);
        idle(12);
        chk(n_adr[15:0], 16'h0, "adr_hold");
        $display("done read_then_exec_write");
        for (int k = 1; k >= 0; k--) begin
            n_dec = 0;
            iss('{st1_wr:1'b1, st1_cpl:k[0], default:'0}, 16'h0);
            iss('{mem_acc:1'b1, default:'0}, 16'h0);
            idle(12);
            chk(n_dec[15:0], 16'h5, "dec_hold");
        end
        $display("done flag_then_access");
        for (int m = 0; m < 2; m++) begin
            rnd(a);
            iss('{dr_wr:1'b1, dr_mmr:m[0], dr_reg:m[1:0], dr_val:a, default:'0}, 16'h0);
            idle(8);
            iss('{dr_rd:1'b1, dr_mmr:1'b1, dr_reg:m[1:0], default:'0}, a);
            iss('{dr_rd:1'b1, dr_reg:m[1:0], default:'0}, a);
            idle(12);
        end
        $display("done data_regs");
        conclude();
    end
endmodule
